// ===== rtl/ubt_consts.vh
// Address map, field positions and reset values of the serial-port timer block.
// Assumes a 16-bit byte address and 8-bit register data.
`ifndef UBT_CONSTS_VH
`define UBT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UBT_ADDR_W            16
`define UBT_DATA_W            8
`define UBT_OFS_TRIM2         16'h281c
`define UBT_OFS_TRIM3         16'h281d
`define UBT_OFS_TRIM4         16'h281e
`define UBT_OFS_TRIM5         16'h281f
`define UBT_OFS_CTRL_STATUS   16'h2838
`define UBT_OFS_MODE          16'h2839
`define UBT_OFS_GP_HIGH       16'h283a
`define UBT_OFS_BG_HIGH       16'h283b
`define UBT_OFS_GP_LOW        16'h283c
`define UBT_OFS_BG_LOW        16'h283d
`define UBT_OFS_SER_CTRL      16'h283e
`define UBT_OFS_SER_BUF       16'h283f

// ----------------------------------------
// Memory word indices
// ----------------------------------------
`define UBT_IDX_W             3
`define UBT_IDX_TRIM5         3'h3
`define UBT_IDX_SER_CTRL      3'h4
`define UBT_IDX_SER_BUF       3'h5

// ----------------------------------------
// Control/status fields
// ----------------------------------------
`define UBT_BIT_BAUD_DOUBLE   7
`define UBT_BIT_BG_CLK_SEL    5
`define UBT_BIT_GP_CLK_SEL    4
`define UBT_BIT_BG_OVF        3
`define UBT_BIT_GP_OVF        2
`define UBT_BIT_BG_RUN        1
`define UBT_BIT_GP_RUN        0
`define UBT_CTRL_RESET        8'h00
`define UBT_CTRL_WR_MASK      8'hbf

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define UBT_MODE_BG_HI        5
`define UBT_MODE_BG_LO        4
`define UBT_MODE_GP_HI        1
`define UBT_MODE_GP_LO        0
`define UBT_MODE_RESET        8'h00

// ----------------------------------------
// Timer modes and prescaler
// ----------------------------------------
`define UBT_TM_13BIT          2'h0
`define UBT_TM_16BIT          2'h1
`define UBT_TM_RELOAD8        2'h2
`define UBT_TM_SPLIT          2'h3
`define UBT_PRESCALE          4'hc

`endif

// ===== rtl/ubt_regmem.v
// Small register memory for trims, serial control and serial buffer bytes.
// Assumes one write or one read per cycle; read data stand one cycle after the strobe.
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_regmem #(
	parameter AW    = 3,
	parameter DW    = 8,
	parameter DEPTH = 8
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          ce,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_idx,
	input  wire [DW-1:0] wr_data,
	input  wire          rd_en,
	input  wire [AW-1:0] rd_idx,
	input  wire          byp_sel,
	input  wire [DW-1:0] byp_data,
	input  wire [AW-1:0] trim_idx,
	output reg  [DW-1:0] rd_data_q,
	output reg  [DW-1:0] trim_q
);

	reg [DW-1:0] mem_q [0:DEPTH-1];
	integer      i;

	// ----------------------------------------
	// Storage and read register
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {DW{1'b0}};
			end
			rd_data_q <= {DW{1'b0}};
			trim_q    <= {DW{1'b0}};
		end else if (ce) begin
			if (wr_en)
				mem_q[wr_idx] <= wr_data;
			// Bypass lets the parent's own registers share this read register
			if (rd_en)
				rd_data_q <= byp_sel ? byp_data : mem_q[rd_idx];
			else
				rd_data_q <= {DW{1'b0}};
			trim_q <= mem_q[trim_idx];
		end
	end

endmodule

// ===== rtl/ubt_timer.v
// One 16-bit timer made of a low and a high byte with four counting modes.
// Assumes a single-cycle count enable from the parent; byte writes win over counting.
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_timer #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         ce,
	input  wire         cnt_en,
	input  wire [1:0]   mode,
	input  wire         wr_lo,
	input  wire         wr_hi,
	input  wire [W-1:0] wr_data,
	output reg  [W-1:0] cnt_lo_q,
	output reg  [W-1:0] cnt_hi_q,
	output reg          ovf_q
);

	function all_ones;
		input [W-1:0] v;
		begin
			all_ones = &v;
		end
	endfunction

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_lo_q <= {W{1'b0}};
			cnt_hi_q <= {W{1'b0}};
			ovf_q    <= 1'b0;
		end else if (ce) begin
			ovf_q <= 1'b0;
			if (wr_lo || wr_hi) begin
				if (wr_lo)
					cnt_lo_q <= wr_data;
				if (wr_hi)
					cnt_hi_q <= wr_data;
			end else if (cnt_en) begin
				case (mode)
				`UBT_TM_13BIT: begin
					// Prescaler part of the low byte is only five bits wide
					if (&cnt_lo_q[4:0]) begin
						cnt_lo_q[4:0] <= 5'h00;
						cnt_hi_q      <= cnt_hi_q + 1'b1;
						ovf_q         <= all_ones(cnt_hi_q);
					end else begin
						cnt_lo_q[4:0] <= cnt_lo_q[4:0] + 1'b1;
					end
				end
				`UBT_TM_16BIT: begin
					{cnt_hi_q, cnt_lo_q} <= {cnt_hi_q, cnt_lo_q} + 1'b1;
					ovf_q <= all_ones(cnt_hi_q) & all_ones(cnt_lo_q);
				end
				`UBT_TM_RELOAD8: begin
					if (all_ones(cnt_lo_q)) begin
						cnt_lo_q <= cnt_hi_q;
						ovf_q    <= 1'b1;
					end else begin
						cnt_lo_q <= cnt_lo_q + 1'b1;
					end
				end
				default: begin
					// Split: two free 8-bit halves, only the low half flags
					cnt_lo_q <= cnt_lo_q + 1'b1;
					cnt_hi_q <= cnt_hi_q + 1'b1;
					ovf_q    <= all_ones(cnt_lo_q);
				end
				endcase
			end
		end
	end

endmodule

// ===== rtl/ubt_top.v
// Baud generator, general timer and register map of one auxiliary serial port.
// Assumes a plain register port on the system clock and an interrupt enable from the CPU.
//
// What this block does
// - Control bit 7 set doubles the port baud rate.
// - Baud generator clock select: zero is clock divided by twelve, one undivided.
// - General timer clock select: zero is clock divided by twelve, one undivided.
// - Baud generator overflow sets its flag and never interrupts.
// - General timer overflow sets its flag; interrupt only when enabled.
// - Baud generator counts only while its run bit is one.
// - General timer counts only while its run bit is one.
// - Four read/write baud trim registers, ports 2 to 5, consecutive addresses.
// - Port-5 baud generator low byte readable and writable.
// - Port-5 general timer low byte readable and writable.
// - Port-5 serial control and buffer registers follow the timer low bytes.
// - Two-bit mode field picks 13-bit, 16-bit, 8-bit reload or split.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_top (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire                   ce,
	input  wire [`UBT_ADDR_W-1:0] addr,
	input  wire [`UBT_DATA_W-1:0] wr_data,
	input  wire                   wr_en,
	input  wire                   rd_en,
	output wire [`UBT_DATA_W-1:0] rd_data,
	input  wire                   gp_irq_en,
	output reg                    gp_irq_q,
	output reg                    baud_tick_q
);

	reg  [7:0] ctrl_q;
	reg  [7:0] mode_q;
	reg  [3:0] pre_q;
	reg        pre_tick_q;
	reg        half_q;
	reg  [7:0] acc_q;
	reg        hold_q;
	wire [7:0] gp_lo;
	wire [7:0] gp_hi;
	wire [7:0] bg_lo;
	wire [7:0] bg_hi;
	wire       gp_ovf;
	wire       bg_ovf;
	wire [7:0] trim;
	wire       bg_en;
	wire       gp_en;
	wire       wr_ctrl;
	wire       raw_tick;
	wire [8:0] acc_sum;
	reg        byp_sel;
	reg  [7:0] byp_data;
	reg        mem_hit;
	reg  [2:0] mem_idx;

	function hit;
		input [`UBT_ADDR_W-1:0] a;
		input [`UBT_ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// trim, serial control and serial buffer addresses
	always @* begin
		mem_hit = 1'b0;
		mem_idx = 3'h0;
		if (addr[`UBT_ADDR_W-1:2] == `UBT_OFS_TRIM2 >> 2) begin
			mem_hit = 1'b1;
			mem_idx = {1'b0, addr[1:0]};
		end else if (hit(addr, `UBT_OFS_SER_CTRL)) begin
			mem_hit = 1'b1;
			mem_idx = `UBT_IDX_SER_CTRL;
		end else if (hit(addr, `UBT_OFS_SER_BUF)) begin
			mem_hit = 1'b1;
			mem_idx = `UBT_IDX_SER_BUF;
		end
	end

	always @* begin
		byp_sel  = ~mem_hit;
		byp_data = 8'h00;
		if (hit(addr, `UBT_OFS_CTRL_STATUS))
			byp_data = ctrl_q & `UBT_CTRL_WR_MASK;
		else if (hit(addr, `UBT_OFS_MODE))
			byp_data = mode_q;
		else if (hit(addr, `UBT_OFS_GP_HIGH))
			byp_data = gp_hi;
		else if (hit(addr, `UBT_OFS_BG_HIGH))
			byp_data = bg_hi;
		else if (hit(addr, `UBT_OFS_GP_LOW))
			byp_data = gp_lo;
		else if (hit(addr, `UBT_OFS_BG_LOW))
			byp_data = bg_lo;
	end

	assign wr_ctrl = wr_en & hit(addr, `UBT_OFS_CTRL_STATUS);

	// ----------------------------------------
	// Clock prescaler
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			pre_q      <= 4'h0;
			pre_tick_q <= 1'b0;
		end else if (ce) begin
			pre_tick_q <= (pre_q == `UBT_PRESCALE - 4'h1);
			if (pre_q == `UBT_PRESCALE - 4'h1)
				pre_q <= 4'h0;
			else
				pre_q <= pre_q + 4'h1;
		end
	end

	assign bg_en = ctrl_q[`UBT_BIT_BG_RUN] & (ctrl_q[`UBT_BIT_BG_CLK_SEL] | pre_tick_q);
	assign gp_en = ctrl_q[`UBT_BIT_GP_RUN] & (ctrl_q[`UBT_BIT_GP_CLK_SEL] | pre_tick_q);

	// ----------------------------------------
	// Control/status and mode registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `UBT_CTRL_RESET;
			mode_q <= `UBT_MODE_RESET;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_q <= wr_data & `UBT_CTRL_WR_MASK;
			if (wr_en && hit(addr, `UBT_OFS_MODE))
				mode_q <= wr_data;
			if (bg_ovf)
				ctrl_q[`UBT_BIT_BG_OVF] <= 1'b1;
			if (gp_ovf)
				ctrl_q[`UBT_BIT_GP_OVF] <= 1'b1;
		end
	end

	always @(posedge clk) begin
		if (!rst_n)
			gp_irq_q <= 1'b0;
		else if (ce)
			gp_irq_q <= ctrl_q[`UBT_BIT_GP_OVF] & gp_irq_en;
	end

	// ----------------------------------------
	// Baud tick with doubling and trim
	// ----------------------------------------
	// doubling passes every overflow
	assign raw_tick = bg_ovf & (ctrl_q[`UBT_BIT_BAUD_DOUBLE] | half_q);
	assign acc_sum  = {1'b0, acc_q} + {1'b0, trim};

	// fractional trim stretch
	// Carry delays the tick one clock, so trim adds fractional bit time
	always @(posedge clk) begin
		if (!rst_n) begin
			half_q      <= 1'b0;
			acc_q       <= 8'h00;
			hold_q      <= 1'b0;
			baud_tick_q <= 1'b0;
		end else if (ce) begin
			if (bg_ovf)
				half_q <= ~half_q;
			baud_tick_q <= hold_q | (raw_tick & ~acc_sum[8]);
			hold_q      <= raw_tick & acc_sum[8];
			if (raw_tick)
				acc_q <= acc_sum[7:0];
		end
	end

	// ----------------------------------------
	// Timers and register memory
	// ----------------------------------------
	ubt_timer #(
		.W (8)
	) u_bg (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.cnt_en   (bg_en),
		.mode     ({mode_q[`UBT_MODE_BG_HI], mode_q[`UBT_MODE_BG_LO]}),
		.wr_lo    (wr_en & hit(addr, `UBT_OFS_BG_LOW)),
		.wr_hi    (wr_en & hit(addr, `UBT_OFS_BG_HIGH)),
		.wr_data  (wr_data),
		.cnt_lo_q (bg_lo),
		.cnt_hi_q (bg_hi),
		.ovf_q    (bg_ovf)
	);

	ubt_timer #(
		.W (8)
	) u_gp (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.cnt_en   (gp_en),
		.mode     ({mode_q[`UBT_MODE_GP_HI], mode_q[`UBT_MODE_GP_LO]}),
		.wr_lo    (wr_en & hit(addr, `UBT_OFS_GP_LOW)),
		.wr_hi    (wr_en & hit(addr, `UBT_OFS_GP_HIGH)),
		.wr_data  (wr_data),
		.cnt_lo_q (gp_lo),
		.cnt_hi_q (gp_hi),
		.ovf_q    (gp_ovf)
	);

	ubt_regmem #(
		.AW    (`UBT_IDX_W),
		.DW    (`UBT_DATA_W),
		.DEPTH (8)
	) u_mem (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.wr_en     (wr_en & mem_hit),
		.wr_idx    (mem_idx),
		.wr_data   (wr_data),
		.rd_en     (rd_en),
		.rd_idx    (mem_idx),
		.byp_sel   (byp_sel),
		.byp_data  (byp_data),
		.trim_idx  (`UBT_IDX_TRIM5),
		.rd_data_q (rd_data),
		.trim_q    (trim)
	);

endmodule

// ===== verification/ubt_checker.sv
// Port checker for the serial-port timer block, bound to its top module.
// Assumes single-cycle strobes and the register map of the block header.
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_checker (
	input wire                   clk,
	input wire                   rst_n,
	input wire                   ce,
	input wire [`UBT_ADDR_W-1:0] addr,
	input wire [`UBT_DATA_W-1:0] wr_data,
	input wire                   wr_en,
	input wire                   rd_en,
	input wire [`UBT_DATA_W-1:0] rd_data,
	input wire                   gp_irq_en,
	input wire                   gp_irq_q,
	input wire                   baud_tick_q
);
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire ctl = addr == `UBT_OFS_CTRL_STATUS;
	wire sto = addr[15:2] == 14'h0a07 || addr[15:1] == 15'h141f;
	wire mpd = addr[15:2] == 14'h0a07 || addr[15:3] == 13'h0507;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_idle_a: assert property ($past(ce) && !$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside read slot");
	unmapped_read_a: assert property ($past(rd_en) && !$past(mpd) |-> rd_data == 8'h00)
		else $error("unmapped read not zero");
	store_readback_a: assert property (rd_en && sto && $past(wr_en) && addr == $past(addr)
		|=> rd_data == $past(wr_data, 2)) else $error("stored byte lost");
	ctrl_readback_a: assert property (rd_en && ctl && $past(wr_en && ctl)
		|=> (rd_data & 8'hb3) == ($past(wr_data, 2) & 8'hb3)) else $error("ctrl bits lost");
	reserved_zero_a: assert property ($past(rd_en && ctl) |-> !rd_data[6])
		else $error("reserved ctrl bit set");
	irq_mask_a: assert property ($past(ce) && !$past(gp_irq_en) |-> !gp_irq_q)
		else $error("masked interrupt raised");
	irq_flag_a: assert property ($past(rd_en && ctl)
		|-> gp_irq_q == (rd_data[2] && $past(gp_irq_en))) else $error("irq not from gp flag");
	flag_hold_a: assert property (gp_irq_q && gp_irq_en && ce && !$past(wr_en && ctl)
		|=> gp_irq_q) else $error("gp flag dropped");
endmodule

bind ubt_top ubt_checker chk_i (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.gp_irq_en(gp_irq_en), .gp_irq_q(gp_irq_q), .baud_tick_q(baud_tick_q));

// ===== verification/ubt_top_bench.sv
// Self-checking bench for the serial-port timer block.
// Assumes it is the only driver of the block ports; ce is low only in the freeze test.
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_top_bench;
	localparam logic [15:0] CS = `UBT_OFS_CTRL_STATUS;
	localparam logic [15:0] GL = `UBT_OFS_GP_LOW;
	localparam logic [15:0] BL = `UBT_OFS_BG_LOW;
	reg         clk = 0, rst_n = 0, ce = 1, wr_en = 0, rd_en = 0, gp_irq_en = 0;
	reg  [15:0] addr = 0, a;
	reg  [7:0]  wr_data = 0, v, r, c;
	wire [7:0]  rd_data;
	wire        gp_irq_q, baud_tick_q;
	int         miscompares = 0, check_count = 0, n1, n2, i;

	always #12.5 clk = ~clk;

	ubt_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .gp_irq_en(gp_irq_en),
		.gp_irq_q(gp_irq_q), .baud_tick_q(baud_tick_q));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function logic [7:0] in(int x, int lo, int hi);
		return 8'(x >= lo && x <= hi);
	endfunction
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// Strobe stays up so writes can follow back to back; rd or idle drops it
	task wr(input logic [15:0] x, input logic [7:0] d);
		addr <= x;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
	endtask
	task idle(input int n);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	// Data stand one cycle only, so sample at mid-cycle
	task rd(input logic [15:0] x, output logic [7:0] d);
		wr_en <= 1'b0;
		addr <= x;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		d = rd_data;
		@(posedge clk);
	endtask
	task irq(input logic e);
		@(negedge clk);
		chk("irq", 8'(gp_irq_q), 8'(e));
		@(posedge clk);
	endtask
	task ticks(input logic [7:0] k, output int n);
		wr(CS, k);
		idle(0);
		n = 0;
		repeat (96) @(negedge clk) n += baud_tick_q;
		@(posedge clk);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		#1ms;
		miscompares++;
		final_report;
	end
	initial begin
		void'($urandom(32'h084a34bf));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 12; i++) begin
			a = i < 4 ? 16'h281c + 16'(i) : 16'h2834 + 16'(i);
			rd(a, r);
			chk("reset", r, 8'h00);
		end
		for (i = 0; i < 12; i++) begin
			a = i < 4 ? 16'h281c + 16'(i) : 16'h2834 + 16'(i);
			v = 8'($urandom);
			if (i == 5) v = v & 8'h33;
			if (i != 4) begin
				wr(a, v);
				rd(a, r);
				chk("store", r, v);
			end
		end
		wr(16'h2820, 8'hff);
		rd(16'h2820, r);
		chk("unmapped", r, 8'h00);
		wr(CS, 8'hf0);
		rd(CS, r);
		chk("ctrl", r, 8'hb0);
		$display("test registers done");
		wr(`UBT_OFS_MODE, 8'h11);
		wr(`UBT_OFS_GP_HIGH, 8'h00);
		wr(`UBT_OFS_BG_HIGH, 8'h00);
		// Clock select by ratio, run bit by a frozen count
		for (i = 0; i < 4; i++) begin
			a = i[1] ? BL : GL;
			c = i[1] ? {2'b00, i[0], 5'h02} : {3'b000, i[0], 4'h1};
			wr(a, 8'h00);
			wr(CS, c);
			idle(120);
			wr(CS, 8'h00);
			rd(a, r);
			chk("rate", in(r, i[0] ? 115 : 8, i[0] ? 125 : 12), 8'h01);
			repeat (20) @(posedge clk);
			rd(a, v);
			chk("stop", v, r);
		end
		$display("test clocks done");
		// 13-bit and split modes both wrap on the second count from 0xfffe
		for (i = 0; i < 2; i++) begin
			wr(`UBT_OFS_MODE, i ? 8'h03 : 8'h00);
			wr(`UBT_OFS_GP_HIGH, 8'hff);
			wr(GL, 8'hfe);
			wr(CS, 8'h11);
			idle(6);
			rd(CS, r);
			chk("mode flag", r, 8'h15);
			wr(CS, 8'h00);
			rd(`UBT_OFS_GP_HIGH, r);
			rd(GL, v);
			chk("mode high", in(r, i, i ? 15 : 0), 8'h01);
			chk("mode low", v & 8'hf0, i ? 8'h00 : 8'he0);
		end
		$display("test modes done");
		wr(`UBT_OFS_MODE, 8'h11);
		wr(`UBT_OFS_GP_HIGH, 8'hff);
		wr(GL, 8'hfe);
		wr(CS, 8'h11);
		idle(6);
		rd(CS, r);
		chk("gp flag", r, 8'h15);
		irq(1'b0);
		gp_irq_en <= 1'b1;
		@(posedge clk);
		irq(1'b1);
		repeat (5) @(posedge clk);
		irq(1'b1);
		wr(CS, 8'h10);
		idle(1);
		irq(1'b0);
		wr(CS, 8'h04);
		rd(CS, r);
		chk("flag set", r, 8'h04);
		irq(1'b1);
		wr(CS, 8'h00);
		// Clock enable low must freeze the running timer
		wr(GL, 8'h00);
		wr(CS, 8'h11);
		ce <= 1'b0;
		idle(20);
		ce <= 1'b1;
		wr(CS, 8'h00);
		rd(GL, v);
		chk("freeze", v, 8'h01);
		$display("test overflow done");
		wr(`UBT_OFS_MODE, 8'h21);
		wr(`UBT_OFS_BG_HIGH, 8'hfe);
		wr(BL, 8'hfe);
		wr(`UBT_OFS_TRIM5, 8'h00);
		ticks(8'h22, n1);
		chk("ticks", in(n1, 22, 26), 8'h01);
		ticks(8'ha2, n2);
		chk("double", in(n2, 46, 50), 8'h01);
		rd(CS, r);
		chk("bg flag", r, 8'haa);
		irq(1'b0);
		ticks(8'h20, n1);
		chk("bg stop", in(n1, 0, 1), 8'h01);
		$display("test baud done");
		final_report;
	end
endmodule
